// ---- src/frame_pkg.sv ----
package frame_pkg;
  localparam int ADDR_W = 16;
  localparam int CTRL_W = 8;
  localparam int BYTE_W = 8;
  localparam int BLK_W = 5;
  localparam int LEN_W = 2;
  localparam int DIR_POS = 2;
  localparam int BLK_LSB = 3;
  localparam logic [1:0] LEN_VAR = 2'h0;
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [1:0] LEN_FOUR = 2'h3;
  localparam logic [1:0] BLK_RSV_LOW = 2'h0;
  localparam logic [4:0] BLK_COMMON = 5'h00;
  localparam logic DIR_READ = 1'b0;
  localparam logic DIR_WRITE = 1'b1;
  localparam logic [2:0] CNT_ONE = 3'h1;
  localparam logic [2:0] CNT_TWO = 3'h2;
  localparam logic [2:0] CNT_FOUR = 3'h4;

  typedef struct packed {
    logic [4:0] block;
    logic dir;
    logic [1:0] len_mode;
  } ctrl_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [4:0] block;
    logic valid;
  } access_t;
endpackage

// ---- src/pin_sync.sv ----
`timescale 1ns/1ns
module pin_sync #(
  parameter int WIDTH = 3
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      meta_q <= '1;
      o_sync <= '1;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule

// ---- src/spi_slave_frame_engine.sv ----
`timescale 1ns/1ns
// Notes on behaviour
// - Length mode 11 means four data bytes
// - Data length from length mode field
// - Bytes shift most significant bit first
// - Variable mode lasts while select low
// - Sequential write bytes to successive offsets
// - Read: device drives data on out-line
// - Sequential read from successive offsets
// - Fixed mode ends after 1/2/4 bytes
// - Fixed frames share variable frame layout
// - One byte write layout, mode 01
// - Two byte write uses mode 10
// - Four byte write uses mode 11
// - Frame: 16-bit address, control, data
// - Block select; low bits 00 reserved, except common block 00000
// - Offset increments after each byte
module spi_slave_frame_engine
  import frame_pkg::*;
#(
  parameter int CNT_W = 3
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_sclk,
  input wire logic i_frame_select_n,
  input wire logic i_mosi,
  output logic o_miso,
  output logic o_miso_oe_n,
  output frame_pkg::access_t o_wr_access,
  output logic [7:0] o_wr_data,
  output frame_pkg::access_t o_rd_req,
  input wire logic [7:0] i_rd_data,
  output logic o_block_reserved
);
  import frame_pkg::*;

  typedef enum logic [1:0] {ST_ADDR, ST_CTRL, ST_DATA} phase_t;

  logic [2:0] pins;
  logic sclk_s;
  logic sel_n_s;
  logic mosi_s;
  logic sclk_d1_q;
  phase_t phase_q;
  logic [4:0] bit_q;
  logic [15:0] addr_q;
  logic [7:0] shift_q;
  ctrl_t ctrl_q;
  logic [CNT_W-1:0] bytes_q;
  logic [7:0] tx_q;

  pin_sync #(.WIDTH(3)) u_sync (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_async({i_sclk, i_frame_select_n, i_mosi}),
    .o_sync(pins)
  );
  assign sclk_s = pins[2];
  assign sel_n_s = pins[1];
  assign mosi_s = pins[0];

  function automatic logic [CNT_W-1:0] fixed_count(logic [1:0] m);
    unique case (m)
      LEN_ONE: fixed_count = CNT_W'(CNT_ONE);
      LEN_TWO: fixed_count = CNT_W'(CNT_TWO);
      LEN_FOUR: fixed_count = CNT_W'(CNT_FOUR);
      default: fixed_count = '0;
    endcase
  endfunction

  localparam logic [4:0] ADDR_LAST = 5'(ADDR_W - 1);
  localparam logic [2:0] BIT_LAST = 3'(BYTE_W - 1);

  phase_t phase_d;
  logic [4:0] bit_d;
  logic [15:0] addr_d;
  logic [7:0] shift_d;
  ctrl_t ctrl_d;
  logic [CNT_W-1:0] bytes_d;
  logic [7:0] tx_d;
  logic miso_d;
  logic rd_load_q;

  // Edges of the synchronised serial clock, only while selected
  wire active = ~sel_n_s;
  wire rise = active & sclk_s & ~sclk_d1_q;
  wire fall = active & ~sclk_s & sclk_d1_q;
  wire [7:0] shifted = {shift_q[6:0], mosi_s};
  wire in_addr = phase_q == ST_ADDR;
  wire in_ctrl = phase_q == ST_CTRL;
  wire in_data = phase_q == ST_DATA;
  wire byte_done = rise & (bit_q[2:0] == BIT_LAST);
  wire addr_done = in_addr & rise & (bit_q == ADDR_LAST);
  wire ctrl_done = in_ctrl & byte_done;
  wire data_done = in_data & byte_done;
  wire ctrl_t new_ctrl = ctrl_t'(shifted);
  wire is_write = ctrl_q.dir == DIR_WRITE;
  wire fixed = ctrl_q.len_mode != LEN_VAR;
  wire [CNT_W-1:0] next_bytes = bytes_q + CNT_W'(1);
  wire fixed_end = fixed & (next_bytes == fixed_count(ctrl_q.len_mode));
  wire [15:0] next_addr = addr_q + 16'h0001;
  wire new_read = ctrl_done & (new_ctrl.dir == DIR_READ);
  wire more_read = data_done & ~is_write & ~fixed_end;
  wire [1:0] blk_low = new_ctrl.block[1:0];
  wire read_data = active & in_data & ~is_write;
  wire tx_shift = fall & read_data;

  // Frame phase
  always_comb begin
    phase_d = phase_q;
    if (!active) begin
      phase_d = ST_ADDR;
    end else if (addr_done) begin
      phase_d = ST_CTRL;
    end else if (ctrl_done) begin
      phase_d = ST_DATA;
    end else if (data_done & fixed_end) begin
      phase_d = ST_ADDR;
    end
  end

  // Bit position within the current phase or byte
  always_comb begin
    bit_d = bit_q;
    if (!active) begin
      bit_d = '0;
    end else if (addr_done | ctrl_done | data_done) begin
      bit_d = '0;
    end else if (rise) begin
      bit_d = bit_q + 5'h01;
    end
  end

  // Offset shifts in, then steps once per data byte
  always_comb begin
    addr_d = addr_q;
    if (rise & in_addr) begin
      addr_d = {addr_q[14:0], mosi_s};
    end else if (data_done) begin
      addr_d = next_addr;
    end
  end

  // Data bytes seen in the current frame
  always_comb begin
    bytes_d = bytes_q;
    if (!active) begin
      bytes_d = '0;
    end else if (ctrl_done) begin
      bytes_d = '0;
    end else if (data_done) begin
      bytes_d = next_bytes;
    end
  end

  assign shift_d = rise ? shifted : shift_q;
  assign ctrl_d = ctrl_done ? new_ctrl : ctrl_q;

  // Read byte loads the cycle after its request is seen
  always_comb begin
    tx_d = tx_q;
    if (rd_load_q) begin
      tx_d = i_rd_data;
    end else if (tx_shift) begin
      tx_d = {tx_q[6:0], 1'b0};
    end
  end

  assign miso_d = tx_shift ? tx_q[7] : o_miso;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sclk_d1_q <= '1;
    end else begin
      sclk_d1_q <= sclk_s;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      phase_q <= ST_ADDR;
      bit_q <= '0;
      bytes_q <= '0;
    end else begin
      phase_q <= phase_d;
      bit_q <= bit_d;
      bytes_q <= bytes_d;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      addr_q <= '0;
      shift_q <= '0;
      ctrl_q <= '0;
    end else begin
      addr_q <= addr_d;
      shift_q <= shift_d;
      ctrl_q <= ctrl_d;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_wr_access <= '0;
      o_wr_data <= '0;
      o_rd_req <= '0;
      o_block_reserved <= 1'b0;
    end else begin
      o_wr_access.valid <= data_done & is_write;
      o_wr_access.addr <= addr_q;
      o_wr_access.block <= ctrl_q.block;
      o_wr_data <= shifted;
      o_rd_req.valid <= new_read | more_read;
      o_rd_req.addr <= new_read ? addr_q : next_addr;
      o_rd_req.block <= new_read ? new_ctrl.block : ctrl_q.block;
      if (ctrl_done) begin
        o_block_reserved <= (blk_low == BLK_RSV_LOW) &
          (new_ctrl.block != BLK_COMMON);
      end
    end
  end

  // First read bit is driven on the falling edge after its load
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rd_load_q <= '0;
      tx_q <= '0;
      o_miso <= '0;
      o_miso_oe_n <= '1;
    end else begin
      rd_load_q <= o_rd_req.valid;
      tx_q <= tx_d;
      o_miso <= miso_d;
      o_miso_oe_n <= ~read_data;
    end
  end
endmodule

// ---- bench/spi_frame_checker.sv ----
`timescale 1ns/1ns
module spi_frame_checker
  import frame_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_frame_select_n,
  input wire logic o_miso_oe_n,
  input wire frame_pkg::access_t o_wr_access,
  input wire frame_pkg::access_t o_rd_req,
  input wire logic o_block_reserved
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  wire w = o_wr_access.valid;
  wire r = o_rd_req.valid;
  property p_wp; w |=> !w; endproperty
  a_wp: assert property (p_wp) else $error("long write pulse");
  property p_rp; r |=> !r; endproperty
  a_rp: assert property (p_rp) else $error("long read pulse");
  property p_ex; !(w && r); endproperty
  a_ex: assert property (p_ex) else $error("read and write");
  property p_oe; !o_miso_oe_n |-> !w; endproperty
  a_oe: assert property (p_oe) else $error("write in read");
  property p_idle; i_frame_select_n [*6] |-> o_miso_oe_n && !w && !r;
  endproperty
  a_idle: assert property (p_idle) else $error("busy while idle");
  property p_wi; logic [20:0] a; (w, a = o_wr_access[21:1]) ##[60:68] w
    |-> o_wr_access[21:1] == {a[20:5] + 16'h1, a[4:0]}; endproperty
  a_wi: assert property (p_wi) else $error("write offset");
  property p_ri; logic [15:0] a; (r, a = o_rd_req.addr) ##[60:68] r
    |-> o_rd_req.addr == a + 16'h1; endproperty
  a_ri: assert property (p_ri) else $error("read offset");
  property p_rs; $changed(o_block_reserved) |-> !i_frame_select_n;
  endproperty
  a_rs: assert property (p_rs) else $error("reserved flag");
  c_w: cover property (w);
  c_r: cover property (r);
  c_rs: cover property ($rose(o_block_reserved));
endmodule
bind spi_slave_frame_engine spi_frame_checker u_chk(.i_clk(i_clk),
  .i_sys_rst(i_sys_rst), .i_frame_select_n(i_frame_select_n),
  .o_miso_oe_n(o_miso_oe_n), .o_wr_access(o_wr_access),
  .o_rd_req(o_rd_req), .o_block_reserved(o_block_reserved));

// ---- bench/spi_host.sv ----
`timescale 1ns/1ns
module spi_host (
  input wire logic i_clk,
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_mosi,
  input wire logic i_miso
);
  initial begin
    o_sclk = 0;
    o_cs_n = 1;
    o_mosi = 0;
  end
  task automatic tk(int n);
    repeat (n) @(posedge i_clk);
  endtask
  // Frame bits left-aligned: address, control, up to four data bytes
  task automatic frame(input [55:0] f, input int n, input bit keep,
    output [31:0] q);
    o_cs_n <= 0;
    for (int i = 0; i < 24 + 8 * n; i++) begin
      o_sclk <= 0;
      o_mosi <= f[55-i];
      tk(4);
      o_sclk <= 1;
      tk(3);
      q = {q[30:0], i_miso};
      tk(1);
    end
    o_sclk <= 0;
    o_mosi <= ~o_mosi;
    o_cs_n <= !keep;
    tk(12);
  endtask
endmodule

// ---- bench/tb_top.sv ----
`timescale 1ns/1ns
`define CHK(n, e, v) begin check_count++; if ((v) !== (e)) begin \
  bad_count++; $display("wrong value %s exp %h got %h", n, e, v); end end
module tb_top;
  import frame_pkg::*;
  logic i_clk = 0, i_sys_rst = 1, sclk, cs_n, mosi, miso, oe_n, resv;
  access_t wa, rr;
  logic [7:0] wd, rd = 8'h00;
  logic [31:0] lf = 32'h6e98, q;
  logic [15:0] wad[$];
  logic [7:0] wdt[$];
  int bad_count = 0, check_count = 0, cyc = 0;
  initial forever #10 i_clk = ~i_clk;
  spi_host host(.i_clk(i_clk), .o_sclk(sclk), .o_cs_n(cs_n),
    .o_mosi(mosi), .i_miso(miso));
  spi_slave_frame_engine DUT(.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_sclk(sclk), .i_frame_select_n(cs_n), .i_mosi(mosi), .o_miso(miso),
    .o_miso_oe_n(oe_n), .o_wr_access(wa), .o_wr_data(wd), .o_rd_req(rr),
    .i_rd_data(rd), .o_block_reserved(resv));
  function automatic [31:0] nx(input [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic test_done;
    if (bad_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge i_clk) begin
    if (rr.valid) rd <= rr.addr[7:0] ^ 8'h5a;
    if (wa.valid) wad.push_back(wa.addr);
    if (wa.valid) wdt.push_back(wd);
    cyc++;
    if (cyc > 20000) bad_count++;
    if (cyc > 20000) test_done();
  end
  task automatic run(int m, bit w);
    logic [15:0] a, e;
    int n;
    lf = nx(lf);
    a = (m == 3) ? 16'hfffe : lf[15:0];
    n = (m == 0) ? 3 : (m == 3) ? 4 : m;
    lf = nx(lf);
    wad.delete();
    wdt.delete();
    host.frame({a, lf[4:2], 2'h1, w, m[1:0], lf}, n, m != 0, q);
    for (int k = 0; k < n; k++) begin
      e = a + k[15:0];
      if (w) `CHK("waddr", e, wad[k])
      if (w) `CHK("wdata", lf[31-8*k -: 8], wdt[k])
      if (!w) `CHK("rdata", e[7:0] ^ 8'h5a, q[8*(n-1-k) +: 8])
    end
    if (w) `CHK("wcount", n, wad.size())
  endtask
  initial begin
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 0;
    repeat (4) @(posedge i_clk);
    for (int m = 0; m < 8; m++) run(m % 4, m < 4);
    host.frame({16'h0, 5'h04, 1'b1, 2'h0, 32'h0}, 1, 0, q);
    `CHK("reserved", 1'b1, resv)
    test_done();
  end
endmodule
